// >>> cfs_pkg.sv
package cfs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W    = 10;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned REG_W     = 12;
  localparam int unsigned CORR_W    = 12;
  localparam int unsigned PIPE_LEN  = 11;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONFIG   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_GAIN     = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_PEDESTAL = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_POLARITY = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_CORR     = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_EXT_CLK_BIT = 0;
  localparam int unsigned POL_REF_BIT     = 0;
  localparam int unsigned POL_DATA_BIT    = 1;
  localparam int unsigned POL_BLACK_BIT   = 2;
  localparam int unsigned POL_DUMMY_BIT   = 3;
  localparam int unsigned STS_BLANK_BIT   = 0;
  localparam int unsigned STS_LOOP_BIT    = 1;
  localparam int unsigned STS_CLAMP_BIT   = 2;
  localparam int unsigned GAIN_FRAC_W     = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [0:0]        CONFIG_RST   = 1'h0;
  localparam logic [9:0]        GAIN_RST     = 10'h080;
  localparam logic [3:0]        PEDESTAL_RST = 4'h8;
  localparam logic [3:0]        POLARITY_RST = 4'h0;
  localparam logic [DATA_W-1:0] NEG_REF_CODE = 10'h000;
  // pins at rest under default polarity: pulses high, preblank_n high, clock low
  localparam logic [5:0]        PIN_IDLE     = 6'h1f;

  // ----------------------------------------------------------------
  // latency in conversion ticks; pedestal shift in bits
  // ----------------------------------------------------------------
  localparam int unsigned LAT_NORMAL = 9;
  localparam int unsigned LAT_BLANK  = 11;
  localparam int unsigned PED_SHIFT  = 2;

endpackage

// >>> cfs_gain_stage.sv
module cfs_gain_stage (
  // sample in
  input  wire logic [9:0] cds_level,
  input  wire logic [9:0] gain_code,
  // scaled out
  output logic      [9:0] gained_level
);

  // ----------------------------------------------------------------
  // gain: 2^(code/128 - 1), piecewise linear between octaves
  // ----------------------------------------------------------------
  // code 128 is unity; each 128 codes is one octave (about 6 dB), so
  // the span runs from half to about 2^6.99; a mantissa
  // line stands in for the exponential between octaves
  function automatic logic [9:0] scale(input logic [9:0] lvl, input logic [9:0] code);
    logic [2:0]  oct;
    logic [7:0]  mant;
    logic [17:0] prod;
    logic [25:0] wide;
    oct  = code[9:cfs_pkg::GAIN_FRAC_W];
    mant = {1'b1, code[cfs_pkg::GAIN_FRAC_W-1:0]};
    prod = lvl * mant;
    wide = ({8'h00, prod} << oct) >> 8;
    if (wide > 26'h00003ff) begin
      scale = 10'h3ff;
    end else begin
      scale = wide[9:0];
    end
  endfunction

  assign gained_level = scale(cds_level, gain_code);

endmodule

// >>> cfs_latency_pipe.sv
module cfs_latency_pipe (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // conversion
  input  wire logic       tick,
  input  wire logic       blank,
  input  wire logic [9:0] word_in,
  // output word
  output logic      [9:0] word_out_reg
);

  logic [9:0] stage_reg [cfs_pkg::PIPE_LEN];
  logic [9:0] tap;

  // ----------------------------------------------------------------
  // tap select
  // ----------------------------------------------------------------
  // the output flop adds the last tick, so tap index is latency - 1
  assign tap = blank ? stage_reg[cfs_pkg::LAT_BLANK-1]
                     : stage_reg[cfs_pkg::LAT_NORMAL-1];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < cfs_pkg::PIPE_LEN; i++) begin
        stage_reg[i] <= 10'h000;
      end
      word_out_reg <= 10'h000;
    end else if (tick) begin
      stage_reg[0] <= word_in;
      for (int i = 1; i < cfs_pkg::PIPE_LEN; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
      word_out_reg <= tap;
    end
  end

endmodule

// >>> cfs_sample_ctrl.sv
// The register addresses and strobed register access are this design's own decisions.
module cfs_sample_ctrl (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // timing generator pins
  input  wire logic       ref_sample_pulse,
  input  wire logic       data_sample_pulse,
  input  wire logic       dummy_clamp_pulse,
  input  wire logic       black_clamp_pulse,
  input  wire logic       preblank_n,
  input  wire logic       conversion_clock,
  // digitised sensor level
  input  wire logic [9:0] sensor_input,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [11:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [11:0] reg_rdata,
  // converter side
  output logic      [9:0] adc_data,
  output logic            input_clamp_en,
  output logic            sensor_disconnect,
  output logic            loop_closed
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // order: ref, data, dummy, black, preblank_n, conversion clock
  // reset to resting levels, else a false data edge ticks after reset
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  wire  [5:0] pin_raw = {conversion_clock, preblank_n, black_clamp_pulse,
                         dummy_clamp_pulse, data_sample_pulse, ref_sample_pulse};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= cfs_pkg::PIN_IDLE;
      pin_sync_reg <= cfs_pkg::PIN_IDLE;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // programmable settings
  // ----------------------------------------------------------------
  logic [0:0] config_reg;
  logic [9:0] gain_reg;
  logic [3:0] pedestal_reg;
  logic [3:0] polarity_reg;

  wire wr_config   = reg_wr && (reg_addr == cfs_pkg::ADDR_CONFIG);
  wire wr_gain     = reg_wr && (reg_addr == cfs_pkg::ADDR_GAIN);
  wire wr_pedestal = reg_wr && (reg_addr == cfs_pkg::ADDR_PEDESTAL);
  wire wr_polarity = reg_wr && (reg_addr == cfs_pkg::ADDR_POLARITY);

  // the asynchronous clear is the only way back to defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg   <= cfs_pkg::CONFIG_RST;
      gain_reg     <= cfs_pkg::GAIN_RST;
      pedestal_reg <= cfs_pkg::PEDESTAL_RST;
      polarity_reg <= cfs_pkg::POLARITY_RST;
    end else begin
      if (wr_config) begin
        config_reg <= reg_wdata[cfs_pkg::CFG_EXT_CLK_BIT];
      end
      if (wr_gain) begin
        gain_reg <= reg_wdata[9:0];
      end
      if (wr_pedestal) begin
        pedestal_reg <= reg_wdata[3:0];
      end
      if (wr_polarity) begin
        polarity_reg <= reg_wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // qualified pulses
  // ----------------------------------------------------------------
  // polarity bit high means active high; low (default) means active low
  function automatic logic qualify(input logic pin, input logic active_high);
    qualify = active_high ? pin : ~pin;
  endfunction

  wire ref_act   = qualify(pin_sync_reg[0], polarity_reg[cfs_pkg::POL_REF_BIT]);
  wire data_act  = qualify(pin_sync_reg[1], polarity_reg[cfs_pkg::POL_DATA_BIT]);
  wire dummy_act = qualify(pin_sync_reg[2], polarity_reg[cfs_pkg::POL_DUMMY_BIT]);
  wire black_act = qualify(pin_sync_reg[3], polarity_reg[cfs_pkg::POL_BLACK_BIT]);
  wire blank     = ~pin_sync_reg[4];
  wire conv_lvl  = pin_sync_reg[5];

  // ----------------------------------------------------------------
  // input path and clamp
  // ----------------------------------------------------------------
  wire clamp_on = dummy_act & ref_act;

  // while clamped the input sits at the negative reference level
  wire [9:0] sensor_gated = clamp_on ? cfs_pkg::NEG_REF_CODE : sensor_input;

  // sampling is frozen while blanked so no transient gets in
  wire track_ok = ~blank;

  // ----------------------------------------------------------------
  // correlated double sampling
  // ----------------------------------------------------------------
  logic [9:0] ref_held_reg;
  logic [9:0] data_held_reg;
  logic [9:0] cds_reg;
  logic       data_prev_reg;
  logic       data_trail_d_reg;
  logic       conv_prev_reg;

  wire       data_trail = data_prev_reg & ~data_act;
  wire [9:0] cds_next   = (data_held_reg > ref_held_reg) ? data_held_reg - ref_held_reg
                                                         : 10'h000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_held_reg     <= 10'h000;
      data_held_reg    <= 10'h000;
      cds_reg          <= 10'h000;
      data_prev_reg    <= 1'b0;
      data_trail_d_reg <= 1'b0;
      conv_prev_reg    <= 1'b0;
    end else begin
      data_prev_reg    <= data_act;
      data_trail_d_reg <= data_trail;
      conv_prev_reg    <= conv_lvl;
      if (ref_act && track_ok) begin
        ref_held_reg <= sensor_gated;
      end
      if (data_act && track_ok) begin
        data_held_reg <= sensor_gated;
      end
      if (data_trail) begin
        cds_reg <= cds_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion tick
  // ----------------------------------------------------------------
  // internal mode waits one cycle after the data edge so cds_reg is new
  wire conv_rise = conv_lvl & ~conv_prev_reg;
  wire tick      = config_reg[0] ? conv_rise : data_trail_d_reg;

  // ----------------------------------------------------------------
  // gain
  // ----------------------------------------------------------------
  logic [9:0] gained;

  cfs_gain_stage u_gain (
    .cds_level    (cds_reg),
    .gain_code    (gain_reg),
    .gained_level (gained)
  );

  // ----------------------------------------------------------------
  // black level loop
  // ----------------------------------------------------------------
  logic signed [11:0] corr_reg;

  wire        [9:0]  target = {4'h0, pedestal_reg, 2'b00};
  wire signed [12:0] sum_wide = $signed({3'b000, gained}) + 13'(corr_reg);
  wire        [9:0]  level = sum_wide[12]           ? 10'h000 :
                            (sum_wide > 13'sd1023) ? 10'h3ff :
                                                      sum_wide[9:0];
  wire               loop_on = black_act;

  // one step per tick: slow on purpose, so clamp noise stays small
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      corr_reg <= 12'sh000;
    end else if (tick && loop_on) begin
      if (level > target && corr_reg != 12'sh800) begin
        corr_reg <= corr_reg - 12'sh001;
      end else if (level < target && corr_reg != 12'sh7ff) begin
        corr_reg <= corr_reg + 12'sh001;
      end
    end
    // otherwise corr_reg keeps the established correction
  end

  // ----------------------------------------------------------------
  // output pipeline
  // ----------------------------------------------------------------
  // zeros enter at the pipe head while blanked and reach the
  // output on the eleventh tick through the longer tap
  wire [9:0] pipe_in = blank ? 10'h000 : level;

  cfs_latency_pipe u_pipe (
    .clk          (clk),
    .reset_n      (reset_n),
    .tick         (tick),
    .blank        (blank),
    .word_in      (pipe_in),
    .word_out_reg (adc_data)
  );

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  logic clamp_reg;
  logic disc_reg;
  logic loop_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clamp_reg <= 1'b0;
      disc_reg  <= 1'b0;
      loop_reg  <= 1'b0;
    end else begin
      clamp_reg <= clamp_on;
      disc_reg  <= blank;
      loop_reg  <= loop_on;
    end
  end

  assign input_clamp_en    = clamp_reg;
  assign sensor_disconnect = disc_reg;
  assign loop_closed       = loop_reg;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [11:0] rdata_reg;
  logic [11:0] rd_mux;

  wire [11:0] status_word = {9'h000, clamp_reg, loop_reg, disc_reg};

  // unmapped indices read as zero
  always_comb begin
    unique case (reg_addr)
      cfs_pkg::ADDR_CONFIG:   rd_mux = {11'h000, config_reg};
      cfs_pkg::ADDR_GAIN:     rd_mux = {2'b00, gain_reg};
      cfs_pkg::ADDR_PEDESTAL: rd_mux = {8'h00, pedestal_reg};
      cfs_pkg::ADDR_POLARITY: rd_mux = {8'h00, polarity_reg};
      cfs_pkg::ADDR_STATUS:   rd_mux = status_word;
      cfs_pkg::ADDR_CORR:     rd_mux = corr_reg;
      default:                rd_mux = 12'h000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 12'h000;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 12'h000;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// >>> cfs_sample_ctrl_assertions.sv
module cfs_sample_ctrl_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // pins
  input wire logic        ref_sample_pulse,
  input wire logic        data_sample_pulse,
  input wire logic        dummy_clamp_pulse,
  input wire logic        black_clamp_pulse,
  input wire logic        preblank_n,
  input wire logic        conversion_clock,
  input wire logic [9:0]  sensor_input,
  // register port
  input wire logic [2:0]  reg_addr,
  input wire logic [11:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_rdata,
  // outputs
  input wire logic [9:0]  adc_data,
  input wire logic        input_clamp_en,
  input wire logic        sensor_disconnect,
  input wire logic        loop_closed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------
  // settings mirror
  // ------------------------------------------
  logic       cfg_m;
  logic [9:0] gain_m;
  logic [3:0] ped_m;
  logic [3:0] pol_m;
  logic [3:0] hold_m;
  logic [3:0] blk_cnt;
  logic       dat_d;
  wire        dat_on = ~(data_sample_pulse ^ pol_m[1]);
  wire        ref_on = ~(ref_sample_pulse ^ pol_m[0]);
  wire        dum_on = ~(dummy_clamp_pulse ^ pol_m[3]);
  wire        blk_on = ~(black_clamp_pulse ^ pol_m[2]);
  wire [2:0]  sts = {input_clamp_en, loop_closed, sensor_disconnect};
  wire [11:0] exp_rd = (reg_addr == 3'h0) ? {11'h0, cfg_m} :
                       (reg_addr == 3'h1) ? {2'h0, gain_m} :
                       (reg_addr == 3'h2) ? {8'h0, ped_m} :
                       (reg_addr == 3'h3) ? {8'h0, pol_m} : 12'h0;
  // polarity flips and reset release make pins look active briefly
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_m   <= 1'h0;
      gain_m  <= 10'h080;
      ped_m   <= 4'h8;
      pol_m   <= 4'h0;
      hold_m  <= 4'h4;
      blk_cnt <= 4'h0;
      dat_d   <= 1'h0;
    end else begin
      if (reg_wr && reg_addr == 3'h0) cfg_m <= reg_wdata[0];
      if (reg_wr && reg_addr == 3'h1) gain_m <= reg_wdata[9:0];
      if (reg_wr && reg_addr == 3'h2) ped_m <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 3'h3) pol_m <= reg_wdata[3:0];
      hold_m  <= (reg_wr && reg_addr == 3'h3) ? 4'h4 : hold_m - {3'h0, hold_m != 4'h0};
      dat_d   <= dat_on;
      blk_cnt <= preblank_n ? 4'h0 : blk_cnt + {3'h0, dat_d && !dat_on && blk_cnt != 4'hf};
    end
  end
  property p_reset;
    @(posedge clk) disable iff (1'b0) !reset_n |-> adc_data == 10'h0 && reg_rdata == 12'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared during reset");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 12'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data present without a read");
  property p_rdback;
    reg_rd && reg_addr < 3'h6 |=> reg_rdata == $past(exp_rd);
  endproperty
  a_rdback: assert property (p_rdback)
    else $error("setting read back wrong");
  property p_clamp;
    hold_m == 4'h0 |-> input_clamp_en == $past(dum_on && ref_on, 3);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("input clamp not tied to dummy and reference pulses");
  property p_loop;
    hold_m == 4'h0 |-> loop_closed == $past(blk_on, 3);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop state not tied to black clamp pulse");
  property p_disc;
    hold_m == 4'h0 |-> sensor_disconnect == $past(!preblank_n, 3);
  endproperty
  a_disc: assert property (p_disc)
    else $error("disconnect not tied to preblank");
  property p_blank;
    blk_cnt >= 4'hd |-> adc_data == 10'h0;
  endproperty
  a_blank: assert property (p_blank)
    else $error("output not zero after blank ticks");
  property p_status;
    (reg_rd && reg_addr == 3'h6) ##1 $stable(sts) |-> reg_rdata == {9'h0, sts};
  endproperty
  a_status: assert property (p_status)
    else $error("status bits disagree with outputs");
endmodule

bind cfs_sample_ctrl cfs_sample_ctrl_assertions chk_u (.clk, .reset_n, .ref_sample_pulse,
  .data_sample_pulse, .dummy_clamp_pulse, .black_clamp_pulse, .preblank_n, .conversion_clock,
  .sensor_input, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_data,
  .input_clamp_en, .sensor_disconnect, .loop_closed);

// >>> cfs_tg_model.sv
module cfs_tg_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // bench control
  input  wire logic       go,
  input  wire logic [1:0] pol,
  input  wire logic [9:0] ref_lvl,
  input  wire logic [9:0] dat_lvl,
  // sensor side
  output logic            ref_sample_pulse,
  output logic            data_sample_pulse,
  output logic      [9:0] sensor_input,
  output logic            done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] ph_reg;
  wire        ref_on = ph_reg inside {[5'h1 : 5'h3]};
  wire        dat_on = ph_reg inside {[5'h8 : 5'ha]};
  // levels outlast each pulse so the two-flop delay still sees them
  wire        ref_hold = ph_reg inside {[5'h1 : 5'h6]};
  wire        dat_hold = ph_reg inside {[5'h8 : 5'hd]};
  assign done = ph_reg == 5'h14;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_reg            <= 5'h0;
      ref_sample_pulse  <= 1'b1;
      data_sample_pulse <= 1'b1;
      sensor_input      <= 10'h0;
    end else begin
      ph_reg            <= (ph_reg == 5'h0) ? {4'h0, go} : (done ? 5'h0 : ph_reg + 5'h1);
      ref_sample_pulse  <= ~(ref_on ^ pol[0]);
      data_sample_pulse <= ~(dat_on ^ pol[1]);
      // off the hold windows the line keeps changing
      sensor_input      <= ref_hold ? ref_lvl : (dat_hold ? dat_lvl : ~sensor_input);
    end
  end
endmodule

// >>> tb_cfs_sample_ctrl.sv
module tb_cfs_sample_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset_n = 1'b1;
  logic        conv_clk = 1'b0;
  logic        rsp, dsp, go = 1'b0, done;
  logic        dummy_clamp_pulse = 1'b1;
  logic        black_clamp_pulse = 1'b1;
  logic        preblank_n = 1'b1;
  logic [9:0]  sensor_input, adc_data, ref_lvl = 10'h0, dat_lvl = 10'h0, gain_v = 10'h080;
  logic [2:0]  reg_addr = 3'h0;
  logic [11:0] reg_wdata = 12'h0, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic        input_clamp_en, sensor_disconnect, loop_closed;
  logic        dum = 1'b0, blk = 1'b0, blank = 1'b0, chk = 1'b1;
  logic [3:0]  pol = 4'h0;
  logic [9:0]  q[$];
  int          err_count = 0, n_compared = 0, cyc = 0;
  localparam logic [11:0] RST_V [6] = '{12'h0, 12'h080, 12'h8, 12'h0, 12'h0, 12'h0};
  cfs_sample_ctrl dut_u (.clk, .reset_n, .ref_sample_pulse(rsp), .data_sample_pulse(dsp),
    .dummy_clamp_pulse, .black_clamp_pulse, .preblank_n, .conversion_clock(conv_clk),
    .sensor_input, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_data,
    .input_clamp_en, .sensor_disconnect, .loop_closed);
  cfs_tg_model tg_u (.clk, .reset_n, .go, .pol(pol[1:0]), .ref_lvl, .dat_lvl,
    .ref_sample_pulse(rsp), .data_sample_pulse(dsp), .sensor_input, .done);
  initial forever #2.5 clk = ~clk;
  always_ff @(posedge clk) begin
    dummy_clamp_pulse <= ~(dum ^ pol[3]);
    black_clamp_pulse <= ~(blk ^ pol[2]);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [11:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, e);
  endtask
  // gain law as chosen by the design: 128 codes per octave
  function automatic logic [9:0] expw(input logic [9:0] r, input logic [9:0] d, input logic dm);
    logic [31:0] x;
    x = dm ? {22'h0, d} : (d > r ? {22'h0, d - r} : 32'h0);
    x = ((x * (32'h80 + gain_v[6:0])) << gain_v[9:7]) >> 8;
    return (x > 32'h3ff) ? 10'h3ff : x[9:0];
  endfunction
  task automatic px(input logic [9:0] r, input logic [9:0] d, input logic dm);
    int n;
    int lat;
    @(posedge clk);
    ref_lvl <= r;
    dat_lvl <= d;
    dum     <= dm;
    go      <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("pixel done", {11'h0, done}, 12'h1);
    q.push_back(blank ? 10'h0 : expw(r, d, dm));
    lat = blank ? 11 : 9;
    if (chk && q.size() > lat) check("adc_data", {2'h0, adc_data}, {2'h0, q[q.size()-1-lat]});
  endtask
  // external conversion clock pulses, slow enough for the two-flop sync
  task automatic conv(input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      conv_clk <= 1'b1;
      repeat (2) @(posedge clk);
      conv_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    #1;
  endtask
  task automatic burst(input int cnt, input int dm_at);
    logic [9:0] r;
    for (int i = 0; i < cnt; i++) begin
      r = 10'($urandom_range(255));
      px(r, (i == 3) ? r - 10'h1 : r + 10'($urandom_range(511)), i == dm_at);
    end
  endtask
  initial begin
    reset_n <= 1'b0;
    gain_v = 10'($urandom(77308)) | 10'h080;
    gain_v = 10'h080;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) rd(3'(i), RST_V[i]);
    burst(14, 2);
    gain_v = 10'($urandom_range(1023));
    wr(3'h1, {2'h0, gain_v});
    rd(3'h1, {2'h0, gain_v});
    q.delete();
    burst(12, 20);
    @(posedge clk) preblank_n <= 1'b0;
    blank = 1'b1;
    burst(14, 20);
    rd(3'h6, 12'h1);
    @(posedge clk) preblank_n <= 1'b1;
    blank = 1'b0;
    burst(11, 20);
    wr(3'h1, 12'h080);
    gain_v = 10'h080;
    wr(3'h3, 12'hb);
    pol = 4'hb;
    rd(3'h3, 12'hb);
    q.delete();
    burst(12, 1);
    chk = 1'b0;
    blk = 1'b1;
    repeat (5) px(10'h0, 10'h64, 1'b1);
    blk = 1'b0;
    rd(3'h7, 12'hffb);
    repeat (3) px(10'h0, 10'h64, 1'b0);
    rd(3'h7, 12'hffb);
    @(posedge clk) reset_n <= 1'b0;
    pol = 4'h0;
    @(posedge clk) reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(3'h3, 12'h0);
    rd(3'h1, 12'h080);
    wr(3'h0, 12'h1);
    rd(3'h0, 12'h1);
    px(10'h10, 10'h50, 1'b0);
    conv(9);
    check("adc_data", {2'h0, adc_data}, 12'h0);
    conv(1);
    check("adc_data", {2'h0, adc_data}, {2'h0, expw(10'h10, 10'h50, 1'b0)});
    stop_test();
  end
endmodule
